// ---- logic/dmx_exec.sv ----
/*
  Execution unit for the data move group: special register reads, working
  register moves, table pointer loads, indirect write and table fetch.
  Assumes an APB master on clk, a pin-level change sense port and same-clock
  serial status and table ROM data.
*/
`timescale 1ns/100ps
module dmx_exec import dmx_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic [3:0] change_sense_port,
  input wire logic [3:0] serial_status_in,
  output logic [7:0] rom_addr,
  input wire logic [3:0] rom_data,
  output logic [3:0] accumulator,
  output logic zero_flag,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dmx_state_t st_ff, nxt_st;
  dmx_op_t op_ff, dec_op;
  logic [15:0] instr_ff;
  logic [3:0] acc_ff, page_ff, table_pointer_low_ff, table_pointer_high_ff, ptr_ff;
  logic zf_ff;
  logic [3:0] cs_meta_ff, cs_sync_ff, cs_prev_ff, chg_ff, chg_clr;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, irq_ev, irq_clr;
  logic [31:0] prdata_ff;
  logic mem_we;
  logic [6:0] mem_addr;
  logic [3:0] mem_wdata, mem_rdata, mv;
  logic [6:0] r_fld;
  logic [3:0] w_fld;
  logic wr_en, wr_instr, start_ok, long_op, acc_op, ev_done, map_hit;

  assign r_fld = instr_ff[INS_R_LSB +: INS_R_W];
  assign w_fld = instr_ff[INS_W_LSB +: INS_W_W];

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic dmx_op_t decode(input logic [15:0] w);
    dmx_op_t o;
    o = OP_BAD;
    case (w[15:7])
      OPC_PAGE_RD: o = OP_PAGE_RD;
      OPC_CHG_RD: o = OP_CHG_RD;
      OPC_SER_RD: o = OP_SER_RD;
      OPC_PAGE_LD: o = OP_PAGE_LD;
      OPC_TABLE_POINTER_LOW_LD: o = OP_TABLE_POINTER_LOW_LD;
      OPC_TABLE_POINTER_HIGH_LD: o = OP_TABLE_POINTER_HIGH_LD;
      OPC_TBL_FETCH: o = OP_TBL_FETCH;
      default: begin
        case (w[15:11])
          OPC_WR_ST: o = OP_WR_ST;
          OPC_WR_LD: o = OP_WR_LD;
          OPC_IND_WR: o = OP_IND_WR;
          default: o = OP_BAD;
        endcase
      end
    endcase
    return o;
  endfunction : decode

  assign dec_op = decode(pwdata[15:0]);
  // Indirect write and table fetch run two machine cycles
  assign long_op = (op_ff == OP_IND_WR) || (op_ff == OP_TBL_FETCH);
  assign acc_op = (op_ff == OP_PAGE_RD) || (op_ff == OP_CHG_RD) || (op_ff == OP_SER_RD)
    || (op_ff == OP_WR_ST) || (op_ff == OP_WR_LD);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero wait states; read data are latched in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign wr_instr = wr_en && (paddr == REG_INSTR);
  assign start_ok = wr_instr && (st_ff == ST_IDLE) && (dec_op != OP_BAD);
  assign chg_clr = (wr_en && paddr == REG_CHG_CLR) ? pwdata[3:0] : 4'h0;
  assign irq_clr = (wr_en && paddr == REG_IRQ_CLR) ? pwdata[IRQ_W-1:0] : RST_IRQ;

  // Mapped offsets; status and special are read-only
  always_comb begin
    case (paddr)
      REG_INSTR, REG_CHG_CLR, REG_IRQ_CLR, REG_IRQ_EN: map_hit = 1'b1;
      REG_STATUS, REG_SPECIAL, REG_IRQ_STAT: map_hit = !pwrite;
      default: map_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !map_hit;

  // Read mux captured in the setup phase; write-only offsets read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      case (paddr)
        REG_INSTR: prdata_ff[15:0] <= instr_ff;
        REG_STATUS: begin
          prdata_ff[STAT_ACC_LSB +: 4] <= acc_ff;
          prdata_ff[STAT_ZF_BIT] <= zf_ff;
          prdata_ff[STAT_BUSY_BIT] <= (st_ff != ST_IDLE);
        end
        REG_SPECIAL: begin
          prdata_ff[SP_PAGE_LSB +: 4] <= page_ff;
          prdata_ff[SP_TABLE_POINTER_LOW_LSB +: 4] <= table_pointer_low_ff;
          prdata_ff[SP_TABLE_POINTER_HIGH_LSB +: 4] <= table_pointer_high_ff;
          prdata_ff[SP_CHG_LSB +: 4] <= chg_ff;
          prdata_ff[SP_SER_LSB +: 4] <= serial_status_in;
        end
        REG_IRQ_STAT: prdata_ff[IRQ_W-1:0] <= irq_stat_ff;
        REG_IRQ_EN: prdata_ff[IRQ_W-1:0] <= irq_en_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_ff;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // A write while busy is dropped and flagged, never queued
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_ff <= RST_INSTR;
      op_ff <= OP_BAD;
    end else if (start_ok) begin
      instr_ff <= pwdata[15:0];
      op_ff <= dec_op;
    end
  end

  // One machine cycle is two clocks: C1 reads, C2 writes back
  always_comb begin
    case (st_ff)
      ST_IDLE: nxt_st = start_ok ? ST_C1 : ST_IDLE;
      ST_C1: nxt_st = ST_C2;
      ST_C2: nxt_st = long_op ? ST_C3 : ST_IDLE;
      ST_C3: nxt_st = ST_C4;
      ST_C4: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ev_done = (st_ff == ST_C2 && !long_op) || (st_ff == ST_C4);

  // ****************************************************************
  // Data path
  // ****************************************************************
  // Value being moved in the write-back clock
  always_comb begin
    case (op_ff)
      OP_PAGE_RD: mv = page_ff;
      OP_CHG_RD: mv = chg_ff;
      OP_SER_RD: mv = serial_status_in;
      default: mv = mem_rdata;
    endcase
  end

  // Memory port: one access per clock, no stalls needed
  always_comb begin
    mem_we = 1'b0;
    mem_addr = r_fld;
    mem_wdata = mv;
    case (st_ff)
      ST_C1: begin
        if (op_ff == OP_WR_ST) begin
          mem_addr = {3'h0, w_fld};
        end
      end
      ST_C2: begin
        case (op_ff)
          OP_PAGE_RD, OP_CHG_RD, OP_SER_RD, OP_WR_ST: mem_we = 1'b1;
          OP_WR_LD: begin
            mem_we = 1'b1;
            mem_addr = {3'h0, w_fld};
          end
          OP_IND_WR: mem_addr = {3'h0, w_fld};
          default: mem_we = 1'b0;
        endcase
      end
      ST_C3: begin
        if (op_ff == OP_IND_WR) begin
          mem_we = 1'b1;
          mem_addr = {page_ff[2:0], ptr_ff};
        end
      end
      ST_C4: begin
        if (op_ff == OP_TBL_FETCH) begin
          mem_we = 1'b1;
          mem_addr = {3'h0, w_fld};
          mem_wdata = rom_data;
        end
      end
      default: mem_we = 1'b0;
    endcase
  end

  dmx_ram u_ram (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Accumulator and zero flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff <= RST_NIB;
      zf_ff <= 1'b0;
    end else if (st_ff == ST_C2 && acc_op) begin
      acc_ff <= mv;
      zf_ff <= (mv == 4'h0);
    end
  end

  // Page, table pointers and indirect pointer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_ff <= RST_NIB;
      table_pointer_low_ff <= RST_NIB;
      table_pointer_high_ff <= RST_NIB;
      ptr_ff <= RST_NIB;
    end else if (st_ff == ST_C2) begin
      case (op_ff)
        OP_PAGE_LD: page_ff <= mem_rdata;
        OP_TABLE_POINTER_LOW_LD: table_pointer_low_ff <= mem_rdata;
        OP_TABLE_POINTER_HIGH_LD: table_pointer_high_ff <= mem_rdata;
        OP_IND_WR: ptr_ff <= mem_rdata;
        default: ptr_ff <= ptr_ff;
      endcase
    end
  end

  // High pointer times 16 plus low pointer
  assign rom_addr = {table_pointer_high_ff, table_pointer_low_ff};
  assign accumulator = acc_ff;
  assign zero_flag = zf_ff;

  // ****************************************************************
  // Change sense port
  // ****************************************************************
  // Two-stage synchroniser, then a history stage for edge detection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_meta_ff <= 4'h0;
      cs_sync_ff <= 4'h0;
      cs_prev_ff <= 4'h0;
    end else begin
      cs_meta_ff <= change_sense_port;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
    end
  end

  // Sticky per pin; a change in the clearing clock wins
  for (genvar i = 0; i < 4; i++) begin : g_chg
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        chg_ff[i] <= 1'b0;
      end else begin
        chg_ff[i] <= (chg_ff[i] && !chg_clr[i]) || (cs_sync_ff[i] != cs_prev_ff[i]);
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_ev[IRQ_DONE_BIT] = ev_done;
  assign irq_ev[IRQ_OVR_BIT] = wr_instr && (st_ff != ST_IDLE);
  assign irq_ev[IRQ_BAD_BIT] = wr_instr && (st_ff == ST_IDLE) && (dec_op == OP_BAD);
  assign irq_ev[IRQ_CHG_BIT] = (cs_sync_ff != cs_prev_ff);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_ff <= RST_IRQ;
      irq_en_ff <= RST_IRQ;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
      if (wr_en && paddr == REG_IRQ_EN) begin
        irq_en_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_wb(dmx_op_t o);
    st_ff == ST_C2 && op_ff == o;
  endsequence

  property p_page_rd;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_PAGE_RD) |-> mem_we && mem_wdata == page_ff ##1 acc_ff == $past(page_ff);
  endproperty
  a_page_rd: assert property (p_page_rd) else $error("page read lost");

  property p_chg_cycle;
    @(posedge clk) disable iff (sys_rst)
    (start_ok && dec_op == OP_CHG_RD) |=> st_ff == ST_C1 ##1 ev_done && mem_we ##1 !ev_done;
  endproperty
  a_chg_cycle: assert property (p_chg_cycle) else $error("change read not one cycle");

  property p_chg_set;
    @(posedge clk) disable iff (sys_rst)
    (cs_sync_ff != cs_prev_ff)
      |=> (chg_ff & $past(cs_sync_ff ^ cs_prev_ff)) == $past(cs_sync_ff ^ cs_prev_ff);
  endproperty
  a_chg_set: assert property (p_chg_set) else $error("change flag not set");

  property p_ser_rd;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_SER_RD) |-> mem_addr == r_fld ##1 acc_ff == $past(serial_status_in);
  endproperty
  a_ser_rd: assert property (p_ser_rd) else $error("serial read lost");

  property p_wr_st;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_WR_ST) |-> mem_we && mem_addr == r_fld ##1 acc_ff == $past(mem_rdata);
  endproperty
  a_wr_st: assert property (p_wr_st) else $error("store went astray");

  property p_wr_ld;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_WR_LD) |-> mem_we && mem_addr == {3'h0, w_fld} && mem_wdata == mem_rdata;
  endproperty
  a_wr_ld: assert property (p_wr_ld) else $error("load went astray");

  property p_table_pointer_low;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_TABLE_POINTER_LOW_LD) |=> table_pointer_low_ff == $past(mem_rdata) && $stable(acc_ff) && $stable(zf_ff);
  endproperty
  a_table_pointer_low: assert property (p_table_pointer_low) else $error("low pointer load wrong");

  property p_table_pointer_high;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_TABLE_POINTER_HIGH_LD) |=> table_pointer_high_ff == $past(mem_rdata) && $stable(zf_ff);
  endproperty
  a_table_pointer_high: assert property (p_table_pointer_high) else $error("high pointer load wrong");

  property p_fetch;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_TBL_FETCH) |-> ##2 mem_we && mem_wdata == rom_data && mem_addr == {3'h0, w_fld};
  endproperty
  a_fetch: assert property (p_fetch) else $error("table fetch not written");

  property p_ind;
    @(posedge clk) disable iff (sys_rst)
    s_wb(OP_IND_WR) |=> mem_we && mem_addr == {page_ff[2:0], $past(mem_rdata)};
  endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");

  property p_zf;
    @(posedge clk) disable iff (sys_rst)
    (st_ff == ST_C2 && acc_op) |=> zf_ff == (acc_ff == 4'h0);
  endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");

  property p_direct;
    @(posedge clk) disable iff (sys_rst)
    (st_ff == ST_C1 && op_ff != OP_WR_ST) |-> mem_addr == r_fld;
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

endmodule : dmx_exec

// ---- logic/dmx_pkg.sv ----
/*
  Constants, types and the register map of the data move execution block.
  Assumes a 50 MHz core clock and an APB master with 32-bit data.
*/
package dmx_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SPECIAL = 8'h08;
  localparam logic [7:0] REG_CHG_CLR = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STAT_ACC_LSB = 0;
  localparam int STAT_ZF_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int SP_PAGE_LSB = 0;
  localparam int SP_TABLE_POINTER_LOW_LSB = 4;
  localparam int SP_TABLE_POINTER_HIGH_LSB = 8;
  localparam int SP_CHG_LSB = 12;
  localparam int SP_SER_LSB = 16;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int IRQ_BAD_BIT = 2;
  localparam int IRQ_CHG_BIT = 3;
  localparam int IRQ_W = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  // ****************************************************************
  // Instruction word layout and opcode prefixes
  // ****************************************************************
  localparam int INS_R_LSB = 0;
  localparam int INS_R_W = 7;
  localparam int INS_W_LSB = 7;
  localparam int INS_W_W = 4;
  localparam logic [8:0] OPC_PAGE_RD = 9'h0bf;
  localparam logic [8:0] OPC_CHG_RD = 9'h09e;
  localparam logic [8:0] OPC_SER_RD = 9'h0be;
  localparam logic [8:0] OPC_PAGE_LD = 9'h0ba;
  localparam logic [8:0] OPC_TABLE_POINTER_LOW_LD = 9'h130;
  localparam logic [8:0] OPC_TABLE_POINTER_HIGH_LD = 9'h131;
  localparam logic [8:0] OPC_TBL_FETCH = 9'h132;
  localparam logic [4:0] OPC_WR_ST = 5'h07;
  localparam logic [4:0] OPC_WR_LD = 5'h0d;
  localparam logic [4:0] OPC_IND_WR = 5'h0a;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_C1 = 3'h1,
    ST_C2 = 3'h3,
    ST_C3 = 3'h2,
    ST_C4 = 3'h6
  } dmx_state_t;

  typedef enum logic [3:0] {
    OP_BAD = 4'h0,
    OP_PAGE_RD = 4'h1,
    OP_CHG_RD = 4'h2,
    OP_SER_RD = 4'h3,
    OP_WR_ST = 4'h4,
    OP_WR_LD = 4'h5,
    OP_TABLE_POINTER_LOW_LD = 4'h6,
    OP_TABLE_POINTER_HIGH_LD = 4'h7,
    OP_PAGE_LD = 4'h8,
    OP_IND_WR = 4'h9,
    OP_TBL_FETCH = 4'ha
  } dmx_op_t;

endpackage : dmx_pkg

// ---- logic/dmx_ram.sv ----
/*
  Data memory of 128 nibbles, working registers in the lowest 16.
  Assumes one access per clock; read data appear one clock after the address.
*/
`timescale 1ns/100ps
module dmx_ram import dmx_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Access port
  input wire logic we,
  input wire logic [6:0] addr,
  input wire logic [3:0] wdata,
  output logic [3:0] rdata
);

  logic [3:0] mem_q [128];
  logic [3:0] rdata_ff;

  // Array write; no reset so it maps onto a RAM macro
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  // Registered read, old data on a same-address write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= RST_NIB;
    end else begin
      rdata_ff <= mem_q[addr];
    end
  end

  assign rdata = rdata_ff;

endmodule : dmx_ram

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for the data move execution block, driven over APB.
  Assumes the dmx_pkg register map, a zero-wait slave and 2-clock machine cycles.
*/
`timescale 1ns/100ps
module tb_top import dmx_pkg::*;;
  // ****************
  // Stimulus and observed nets
  // ****************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] change_sense_port = 4'h0;
  logic [3:0] serial_status_in = 4'h0;
  logic [7:0] rom_addr;
  logic [3:0] rom_data = 4'h0;
  logic [3:0] accumulator;
  logic zero_flag;
  logic irq;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;

  // 50 MHz core clock
  always #10 clk = ~clk;

  dmx_exec dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .change_sense_port(change_sense_port),
    .serial_status_in(serial_status_in), .rom_addr(rom_addr), .rom_data(rom_data),
    .accumulator(accumulator), .zero_flag(zero_flag), .irq(irq));

  // ****************
  // Shared tasks
  // ****************
  task summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start an instruction, then poll the busy bit with a bound
  task exec(input logic [15:0] ins);
    int k;
    apb(1'b1, REG_INSTR, {16'h0, ins});
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && k < 20);
    // A poll that runs out of tries counts as a mismatch
    chk("busy", 32'h0, {31'h0, rd[STAT_BUSY_BIT]});
  endtask : exec

  function automatic logic [15:0] op9(input logic [8:0] o, input logic [6:0] r);
    return {o, r};
  endfunction : op9

  function automatic logic [15:0] op5(input logic [4:0] o, input logic [3:0] w,
      input logic [6:0] r);
    return {o, w, r};
  endfunction : op5

  task acc_is(input logic [3:0] a, input logic z);
    chk("accumulator", {28'h0, a}, {28'h0, accumulator});
    chk("zero_flag", {31'h0, z}, {31'h0, zero_flag});
  endtask : acc_is

  // ****************
  // Scenarios
  // ****************
  task t_reset;
    acc_is(4'h0, 1'b0);
    chk("rom_addr", 32'h0, {24'h0, rom_addr});
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, REG_INSTR, 32'h0);
    chk("instr", 32'h0, rd);
    chk("instr err", 32'h0, {31'h0, er});
  endtask : t_reset

  // Serial status copy, zero flag both ways, done interrupt raise and clear
  task t_serial;
    apb(1'b1, REG_IRQ_EN, 32'h1);
    serial_status_in <= 4'h9;
    exec(op9(OPC_SER_RD, 7'h7f));
    acc_is(4'h9, 1'b0);
    chk("irq done", 32'h1, {31'h0, irq});
    apb(1'b1, REG_IRQ_CLR, 32'h1);
    // Clear lands at the handshake edge; look one edge later
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    serial_status_in <= 4'h0;
    exec(op9(OPC_SER_RD, 7'h40));
    acc_is(4'h0, 1'b1);
  endtask : t_serial

  // Working register load and store through memory
  task t_wreg;
    exec(op5(OPC_WR_LD, 4'h3, 7'h7f));
    acc_is(4'h9, 1'b0);
    exec(op9(OPC_SER_RD, 7'h40));
    exec(op5(OPC_WR_ST, 4'h3, 7'h10));
    acc_is(4'h9, 1'b0);
    exec(op5(OPC_WR_LD, 4'h1, 7'h10));
    acc_is(4'h9, 1'b0);
  endtask : t_wreg

  // Table pointers leave the flags alone and form the fetch address
  task t_table;
    serial_status_in <= 4'h6;
    exec(op9(OPC_SER_RD, 7'h41));
    serial_status_in <= 4'h0;
    exec(op9(OPC_SER_RD, 7'h40));
    exec(op9(OPC_TABLE_POINTER_LOW_LD, 7'h7f));
    exec(op9(OPC_TABLE_POINTER_HIGH_LD, 7'h41));
    acc_is(4'h0, 1'b1);
    apb(1'b0, REG_SPECIAL, 32'h0);
    chk("tab low", 32'h9, {28'h0, rd[SP_TABLE_POINTER_LOW_LSB +: 4]});
    chk("tab high", 32'h6, {28'h0, rd[SP_TABLE_POINTER_HIGH_LSB +: 4]});
    chk("rom_addr", 32'h69, {24'h0, rom_addr});
    rom_data <= 4'ha;
    exec(op9(OPC_TBL_FETCH, 7'h02));
    exec(op5(OPC_WR_ST, 4'h2, 7'h50));
    acc_is(4'ha, 1'b0);
  endtask : t_table

  // Page register with bit 3 set: only bits 2..0 pick the indirect page
  task t_page;
    serial_status_in <= 4'he;
    exec(op9(OPC_SER_RD, 7'h42));
    exec(op9(OPC_PAGE_LD, 7'h42));
    // Serial input differs from the page so the page read is told apart
    serial_status_in <= 4'h0;
    exec(op9(OPC_SER_RD, 7'h40));
    exec(op9(OPC_PAGE_RD, 7'h30));
    acc_is(4'he, 1'b0);
    exec(op5(OPC_WR_LD, 4'h5, 7'h30));
    acc_is(4'he, 1'b0);
    exec(op5(OPC_IND_WR, 4'h2, 7'h7f));
    exec(op5(OPC_WR_LD, 4'h4, 7'h69));
    acc_is(4'ha, 1'b0);
  endtask : t_page

  // Pin change sets a sticky flag, cleared only by the clear register
  task t_change;
    change_sense_port <= 4'h4;
    repeat (6) @(posedge clk);
    change_sense_port <= 4'h0;
    repeat (6) @(posedge clk);
    exec(op9(OPC_CHG_RD, 7'h20));
    acc_is(4'h4, 1'b0);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("chg event", 32'h1, {31'h0, rd[IRQ_CHG_BIT]});
    apb(1'b1, REG_CHG_CLR, 32'h4);
    exec(op9(OPC_CHG_RD, 7'h21));
    acc_is(4'h0, 1'b1);
    exec(op5(OPC_WR_LD, 4'h6, 7'h20));
    acc_is(4'h4, 1'b0);
  endtask : t_change

  // Illegal opcode under mask, write while busy, bus refusals
  task t_faults;
    apb(1'b1, REG_IRQ_EN, 32'h0);
    apb(1'b1, REG_IRQ_CLR, 32'hf);
    apb(1'b1, REG_INSTR, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, REG_IRQ_EN, 32'h4);
    @(posedge clk);
    chk("irq bad", 32'h1, {31'h0, irq});
    // Two-cycle fetch keeps the unit busy when the next write lands
    apb(1'b1, REG_INSTR, {16'h0, op9(OPC_TBL_FETCH, 7'h02)});
    apb(1'b1, REG_INSTR, {16'h0, op9(OPC_SER_RD, 7'h41)});
    repeat (4) @(posedge clk);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("busy write", 32'h1, {31'h0, rd[IRQ_OVR_BIT]});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, REG_STATUS, 32'hf);
    chk("read only err", 32'h1, {31'h0, er});
  endtask : t_faults

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_serial();
    t_wreg();
    t_table();
    t_page();
    t_change();
    t_faults();
    summarize();
  end
endmodule : tb_top
